// ---- rps_ctrl_model.sv ----
// Purpose: Remote controller model acting as the one bus master.
// Assumes: Single word transfers; hready is the slave's hreadyout.
// Notes:   Released address and data lines show inverted values.
`timescale 1ns/10ps
module rps_ctrl_model
    import rps_pkg::*;
(
    // Clock and answer
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One transfer; entered just after a rising edge and left at the data edge.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        hwdata <= ~d;
    endtask

    // Sends a quoted string, a character per write.
    task automatic send_str(input logic [7:0] dl, input string s, input bit close);
        logic [31:0] r;
        logic [31:0] sa;
        sa = {24'h0, ADDR_STRIN};
        xfer(1'b1, sa, {24'h0, dl}, r);
        foreach (s[i]) begin
            xfer(1'b1, sa, {24'h0, s[i]}, r);
            if (s[i] == dl) xfer(1'b1, sa, {24'h0, dl}, r);
        end
        if (close) begin
            xfer(1'b1, sa, {24'h0, dl}, r);
            xfer(1'b1, sa, 32'h2C, r);
        end
    endtask
endmodule

// ---- rps_pkg.sv ----
// Purpose: Constants and types of the remote data parse and sync block.
// Assumes: hclk at 125 MHz; one AHB-Lite slave with 32-bit data.
// Notes:   Addresses, opcodes and characters are named here only.
package rps_pkg;

    // ---
    // Timing
    // ---
    localparam int unsigned SETTLE_MS       = 500;
    localparam int unsigned CLK_KHZ         = 125_000;
    // Milliseconds times kilohertz gives whole clock cycles.
    localparam int unsigned SETTLE_CYC_DEF  = SETTLE_MS * CLK_KHZ;
    localparam int unsigned SETTLE_W        = 26;

    // ---
    // Register byte addresses
    // ---
    localparam logic [7:0] ADDR_CMD      = 8'h00;
    localparam logic [7:0] ADDR_RESULT   = 8'h04;
    localparam logic [7:0] ADDR_RESP     = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_STRIN    = 8'h10;
    localparam logic [7:0] ADDR_SETTINGS = 8'h14;
    localparam logic [7:0] ADDR_NONE     = 8'hFC;

    // ---
    // Command opcodes, written to bits 7:0 of the command register
    // ---
    localparam logic [7:0] OP_LEVEL = 8'h01;
    localparam logic [7:0] OP_OUTP  = 8'h02;
    localparam logic [7:0] OP_FUNC  = 8'h03;
    localparam logic [7:0] OP_FILT  = 8'h04;
    localparam logic [7:0] OP_EESE  = 8'h05;
    localparam logic [7:0] OP_SRE   = 8'h06;
    localparam logic [7:0] OP_EESRQ = 8'h07;
    localparam logic [7:0] OP_WAIT  = 8'h08;
    localparam logic [7:0] OP_VERB  = 8'h09;
    localparam logic [7:0] OP_HEAD  = 8'h0A;
    localparam logic [7:0] OP_CONDQ = 8'h0B;
    localparam logic [7:0] OP_CHARQ = 8'h0C;
    localparam logic [7:0] OP_BOOLQ = 8'h0D;
    localparam logic [7:0] OP_STRQ  = 8'h0E;
    localparam logic [7:0] OP_BLKQ  = 8'h0F;

    // ---
    // Transition filter codes and bit positions
    // ---
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_RISE = 2'h1;
    localparam logic [1:0] FILT_FALL = 2'h2;
    localparam logic [1:0] FILT_BOTH = 2'h3;
    localparam int unsigned SETTLE_BIT = 3;
    localparam logic [15:0] Q88_HALF  = 16'h0080;

    // ---
    // Characters and response layout
    // ---
    localparam logic [7:0] CH_DQ   = 8'h22;
    localparam logic [7:0] CH_SQ   = 8'h27;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_ONE  = 8'h31;
    localparam logic [7:0] CH_TWO  = 8'h32;
    localparam logic [0:6][7:0] KW_VOLT = 56'h564F4C54414745;
    localparam logic [0:6][7:0] KW_CURR = 56'h43555252454E54;
    localparam logic [3:0] KW_FULL  = 4'h7;
    localparam logic [3:0] KW_SHORT = 4'h4;
    localparam logic [3:0] STR_MAX  = 4'h8;
    localparam logic [3:0] RESP_MAX = 4'hC;

    // ---
    // State types
    // ---
    typedef enum logic [1:0] {
        Q_IDLE = 2'b00,
        Q_IN   = 2'b01,
        Q_PAIR = 2'b11
    } rps_qstate_type;

    typedef struct packed {
        rps_qstate_type st;
        logic [7:0]     delim;
    } rps_parse_type;

    typedef struct packed {
        logic                dp_act;
        logic                dp_wr;
        logic [7:0]          dp_addr;
        logic [31:0]         rdata;
        logic                busy;
        logic [15:0]         wait_mask;
        logic                verb;
        logic                head;
        logic                outp;
        logic                func;
        logic [1:0]          filt;
        logic [15:0]         eese;
        logic [7:0]          sre;
        logic [15:0]         eesr;
        logic [31:0]         result;
        logic [SETTLE_W-1:0] settle_cnt;
        logic                cond_d;
        logic                srq;
        logic [23:0]         level;
        logic [11:0][7:0]    resp;
        logic [3:0]          resp_len;
        logic [3:0]          resp_ptr;
        logic [7:0][7:0]     strbuf;
        logic [3:0]          str_len;
    } rps_state_type;

    localparam rps_parse_type PARSE_RST = '0;
    localparam rps_state_type STATE_RST = '0;

endpackage

// ---- rps_quote_parse.sv ----
// Purpose: Decodes a quoted string parameter one character at a time.
// Assumes: Characters arrive only while clock enable is high.
// Notes:   The character after a closing quote is a separator and is dropped.
`timescale 1ns/10ps
module rps_quote_parse (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Character stream
    rps_str_if.parse sp
);
    import rps_pkg::*;

    rps_parse_type s_ff;
    rps_parse_type nxt_s;

    // ---
    // Decoder
    // ---
    // Either quote opens a string; a lone copy of the opening quote closes it.
    always_comb begin
        nxt_s      = s_ff;
        sp.out_vld = 1'b0;
        sp.out_chr = sp.in_chr;
        sp.open_p  = 1'b0;
        sp.active  = (s_ff.st != Q_IDLE);
        if (sp.in_vld) begin
            case (s_ff.st)
                Q_IDLE: begin
                    if (sp.in_chr == CH_DQ || sp.in_chr == CH_SQ) begin
                        nxt_s.st    = Q_IN;
                        nxt_s.delim = sp.in_chr;
                        sp.open_p   = 1'b1;
                    end
                end
                Q_IN: begin
                    // Without a closing quote we simply stay here, so nothing is flagged.
                    if (sp.in_chr == s_ff.delim) begin
                        nxt_s.st = Q_PAIR;
                    end else begin
                        sp.out_vld = 1'b1;
                    end
                end
                Q_PAIR: begin
                    // A doubled quote stands for one literal quote.
                    if (sp.in_chr == s_ff.delim) begin
                        sp.out_vld = 1'b1;
                        nxt_s.st   = Q_IN;
                    end else begin
                        nxt_s.st = Q_IDLE;
                    end
                end
                default: begin
                    nxt_s.st = Q_IDLE;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= PARSE_RST;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

endmodule

// ---- rps_remote_sync.sv ----
// Purpose: Command engine for remote data elements, responses and settle synchronisation.
// Assumes: A single AHB-Lite master; word transfers only; hready equals our hreadyout.
// Notes:   A command write stalls the bus while a command still runs.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps

// Behaviour
// - Numeric boolean rounds; zero means off.
// - Boolean responses are the characters 1 or 0.
// - Keyword responses follow the verbosity setting.
// - Header setting never changes keyword responses.
// - Doubled quote decodes to one quote.
// - String responses always use double quotes.
// - Missing closing quote is no error.
// - Block data only sent, never accepted.
// - Block response: hash, digit count, length.
// - Commands run strictly one after another.
// - Condition query returns live condition bits.
// - Condition bit 3 high while settling.
// - Falling filter sets event on 1-to-0.
// - Enable mask gates events into summary.
// - Event query clears register after reading.
// - Service request when enabled summary sets.
// - Wait command holds until masked event.
module rps_remote_sync #(
    parameter int unsigned SETTLE_CYC = rps_pkg::SETTLE_CYC_DEF
) (
    // Clock, reset and enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Source and service request
    output logic [23:0]      level,
    output logic             output_on,
    output logic             settling,
    output logic             srq
);
    import rps_pkg::*;

    if (SETTLE_CYC == 0 || SETTLE_CYC >= (1 << SETTLE_W)) begin : g_chk
        $error("SETTLE_CYC must be nonzero and fit the settle counter");
    end

    rps_state_type s_ff;
    rps_state_type nxt_s;
    rps_str_if     sp ();

    logic [15:0] cond;
    logic [7:0]  stb;
    logic        take;
    logic        stall;
    logic        cmd_go;
    logic        ev;
    logic        eesr_clr;
    logic [7:0]  op;
    logic [23:0] arg;
    logic [7:0]  a_addr;
    logic [0:6][7:0] kw;
    logic [3:0]  klen;

    // Rounds a signed 8.8 value to the nearest integer and tests it for zero.
    function automatic logic num_is_on(input logic [15:0] q88);
        logic [16:0] r;
        r = {q88[15], q88} + {1'b0, Q88_HALF};
        return (r[16:8] != 9'h000);
    endfunction

    // ---
    // String parser
    // ---
    rps_quote_parse u_parse (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .sp      (sp.parse)
    );

    // ---
    // Bus handshake and live status
    // ---
    // A command write waits in its data phase until the engine is idle.
    assign stall     = s_ff.dp_act & s_ff.dp_wr & (s_ff.dp_addr == ADDR_CMD) & s_ff.busy;
    assign hreadyout = ce & ~stall;
    assign hresp     = 1'b0;
    assign hrdata    = s_ff.rdata;
    assign take      = ce & hsel & hready & htrans[1];
    assign cmd_go    = s_ff.dp_act & s_ff.dp_wr & hreadyout & (s_ff.dp_addr == ADDR_CMD);
    assign a_addr    = (haddr[31:8] != 24'h000000) ? ADDR_NONE : haddr[7:0];
    assign op        = hwdata[7:0];
    assign arg       = hwdata[31:8];
    assign sp.in_vld = s_ff.dp_act & s_ff.dp_wr & hreadyout & (s_ff.dp_addr == ADDR_STRIN);
    assign sp.in_chr = hwdata[7:0];

    // Condition bits and the status byte summary.
    always_comb begin
        cond             = 16'h0000;
        cond[SETTLE_BIT] = (s_ff.settle_cnt != '0);
        stb              = 8'h00;
        stb[SETTLE_BIT]  = |(s_ff.eesr & s_ff.eese);
    end

    // Transition filter on the settle bit.
    always_comb begin
        case (s_ff.filt)
            FILT_RISE: ev = ~s_ff.cond_d & cond[SETTLE_BIT];
            FILT_FALL: ev = s_ff.cond_d & ~cond[SETTLE_BIT];
            FILT_BOTH: ev = s_ff.cond_d ^ cond[SETTLE_BIT];
            FILT_NONE: ev = 1'b0;
            default:   ev = 1'b0;
        endcase
    end

    // Keyword for the current function, cut short unless full spelling is on.
    assign kw   = s_ff.func ? KW_CURR : KW_VOLT;
    assign klen = s_ff.verb ? KW_FULL : KW_SHORT;

    // ---
    // Next state
    // ---
    always_comb begin
        nxt_s    = s_ff;
        eesr_clr = 1'b0;

        // Settling countdown.
        if (s_ff.settle_cnt != '0) begin
            nxt_s.settle_cnt = s_ff.settle_cnt - 1'b1;
        end
        nxt_s.cond_d = cond[SETTLE_BIT];

        if (s_ff.dp_act && hreadyout) begin
            nxt_s.dp_act = 1'b0;
        end

        // Release a pending wait once a selected event bit is set.
        if (s_ff.busy && ((s_ff.eesr & s_ff.wait_mask) != 16'h0000)) begin
            nxt_s.busy = 1'b0;
        end

        // Command execution; no opcode takes block data as an operand.
        if (cmd_go) begin
            case (op)
                OP_LEVEL: begin
                    nxt_s.level      = arg;
                    nxt_s.settle_cnt = SETTLE_W'(SETTLE_CYC);
                end
                OP_OUTP: begin
                    nxt_s.outp = num_is_on(arg[15:0]);
                    if (!s_ff.outp && num_is_on(arg[15:0])) begin
                        nxt_s.settle_cnt = SETTLE_W'(SETTLE_CYC);
                    end
                end
                OP_FUNC:  nxt_s.func = arg[0];
                OP_FILT:  nxt_s.filt = arg[1:0];
                OP_EESE:  nxt_s.eese = arg[15:0];
                OP_SRE:   nxt_s.sre  = arg[7:0];
                OP_VERB:  nxt_s.verb = num_is_on(arg[15:0]);
                OP_HEAD:  nxt_s.head = num_is_on(arg[15:0]);
                OP_EESRQ: begin
                    nxt_s.result = {16'h0000, s_ff.eesr};
                    eesr_clr     = 1'b1;
                end
                OP_WAIT: begin
                    nxt_s.busy      = 1'b1;
                    nxt_s.wait_mask = arg[15:0];
                end
                OP_CONDQ: nxt_s.result = {16'h0000, cond};
                OP_CHARQ: begin
                    // The header setting is not consulted here.
                    nxt_s.resp     = '0;
                    nxt_s.resp_len = klen;
                    nxt_s.resp_ptr = 4'h0;
                    for (int i = 0; i < 7; i++) begin
                        if (i < int'(klen)) begin
                            nxt_s.resp[i] = kw[i];
                        end
                    end
                end
                OP_BOOLQ: begin
                    nxt_s.resp     = '0;
                    nxt_s.resp[0]  = s_ff.outp ? CH_ONE : CH_ZERO;
                    nxt_s.resp_len = 4'h1;
                    nxt_s.resp_ptr = 4'h0;
                end
                OP_STRQ: begin
                    nxt_s.resp    = '0;
                    nxt_s.resp[0] = CH_DQ;
                    for (int i = 0; i < 8; i++) begin
                        if (i < int'(s_ff.str_len)) begin
                            nxt_s.resp[i + 1] = s_ff.strbuf[i];
                        end
                    end
                    nxt_s.resp[s_ff.str_len + 4'h1] = CH_DQ;
                    nxt_s.resp_len = s_ff.str_len + 4'h2;
                    nxt_s.resp_ptr = 4'h0;
                end
                OP_BLKQ: begin
                    // Raw condition bytes follow; only bit 3 can be set, so each byte is 00h or 08h.
                    nxt_s.resp     = '0;
                    nxt_s.resp[0]  = CH_HASH;
                    nxt_s.resp[1]  = CH_ONE;
                    nxt_s.resp[2]  = CH_TWO;
                    nxt_s.resp[3]  = cond[15:8];
                    nxt_s.resp[4]  = cond[7:0];
                    nxt_s.resp_len = 4'h5;
                    nxt_s.resp_ptr = 4'h0;
                end
                default: begin
                    nxt_s.busy = s_ff.busy;
                end
            endcase
        end

        // The filter event wins over a clear in the same cycle.
        nxt_s.eesr = eesr_clr ? 16'h0000 : s_ff.eesr;
        if (ev) begin
            nxt_s.eesr[SETTLE_BIT] = 1'b1;
        end

        // Collect decoded string characters; extras beyond the buffer are dropped.
        if (sp.open_p) begin
            nxt_s.str_len = 4'h0;
        end else if (sp.out_vld && s_ff.str_len < STR_MAX) begin
            nxt_s.strbuf[s_ff.str_len[2:0]] = sp.out_chr;
            nxt_s.str_len = s_ff.str_len + 4'h1;
        end

        // Address phase: reads are answered from a register in the data phase.
        if (take) begin
            nxt_s.dp_act  = 1'b1;
            nxt_s.dp_wr   = hwrite;
            nxt_s.dp_addr = a_addr;
            nxt_s.rdata   = 32'h00000000;
            if (!hwrite) begin
                case (a_addr)
                    ADDR_CMD:      nxt_s.rdata = {31'h00000000, s_ff.busy};
                    ADDR_RESULT:   nxt_s.rdata = s_ff.result;
                    ADDR_RESP: begin
                        if (s_ff.resp_ptr < s_ff.resp_len && s_ff.resp_ptr < RESP_MAX) begin
                            nxt_s.rdata    = {23'h000000, 1'b1, s_ff.resp[s_ff.resp_ptr]};
                            nxt_s.resp_ptr = s_ff.resp_ptr + 4'h1;
                        end
                    end
                    ADDR_STATUS:   nxt_s.rdata = {s_ff.busy, 7'h00, stb, cond};
                    ADDR_SETTINGS: nxt_s.rdata = {s_ff.sre, s_ff.eese, 2'b00, s_ff.filt,
                                                  s_ff.func, s_ff.outp, s_ff.head, s_ff.verb};
                    default:       nxt_s.rdata = 32'h00000000;
                endcase
            end
        end

        // Service request follows the enabled status summary.
        nxt_s.srq = |(stb & s_ff.sre);
    end

    // ---
    // State register and outputs
    // ---
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= STATE_RST;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    assign level     = s_ff.level;
    assign output_on = s_ff.outp;
    assign settling  = s_ff.cond_d;
    assign srq       = s_ff.srq;

endmodule

// ---- rps_remote_sync_properties.sv ----
// Purpose: Port checks for the remote sync block.
// Assumes: hready is the block's own hreadyout; one clock domain.
// Notes:   Helper logic tracks command writes.
`timescale 1ns/10ps
module rps_remote_sync_properties
    import rps_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = 20
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Source
    input wire logic [23:0] level,
    input wire logic        output_on,
    input wire logic        settling
);
    // ---
    // Helper logic
    // ---
    logic             dp_cmd_ff;
    logic             dp_st_ff;
    int unsigned      age_ff;
    wire logic        take = hsel & hready & htrans[1] & ce;
    wire logic        fire = dp_cmd_ff & hready & ce;
    wire logic [15:0] qsum = hwdata[23:8] + 16'h0080;
    wire logic        on_req = qsum[15:8] != 8'h00;
    wire logic        rst_op = (hwdata[7:0] == OP_LEVEL) | ((hwdata[7:0] == OP_OUTP) & on_req & ~output_on);
    wire logic        restart = fire & rst_op;

    // Age saturates past the window, so a long idle never wraps it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_cmd_ff <= 1'b0;
            dp_st_ff <= 1'b0;
            age_ff <= SETTLE_CYC + 2;
        end else begin
            if (hready & ce) begin
                dp_cmd_ff <= take & hwrite & (haddr == {24'h0, ADDR_CMD});
                dp_st_ff <= take & ~hwrite & (haddr == {24'h0, ADDR_STATUS});
            end
            if (restart) age_ff <= 1;
            else if (ce && age_ff < SETTLE_CYC + 2) age_ff <= age_ff + 1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_level;
        fire && hwdata[7:0] == OP_LEVEL |=> level == $past(hwdata[31:8]);
    endproperty
    a_level: assert property (p_level) else $error("level not applied");
    property p_set_on;
        restart |-> ##2 settling;
    endproperty
    a_set_on: assert property (p_set_on) else $error("settle not raised");
    property p_set_hold;
        age_ff >= 2 && age_ff <= SETTLE_CYC + 1 |-> settling;
    endproperty
    a_set_hold: assert property (p_set_hold) else $error("settle dropped early");
    property p_set_off;
        age_ff == SETTLE_CYC + 2 |-> !settling;
    endproperty
    a_set_off: assert property (p_set_off) else $error("settle stayed high");
    property p_rise;
        $rose(settling) |-> age_ff == 2;
    endproperty
    a_rise: assert property (p_rise) else $error("settle rose unasked");
    property p_outp;
        fire && hwdata[7:0] == OP_OUTP |=> output_on == $past(on_req);
    endproperty
    a_outp: assert property (p_outp) else $error("output not rounded");
    property p_cond;
        dp_st_ff && hready |-> hrdata[SETTLE_BIT] == settling;
    endproperty
    a_cond: assert property (p_cond) else $error("bit 3 not live");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
endmodule

bind rps_remote_sync rps_remote_sync_properties #(.SETTLE_CYC(SETTLE_CYC)) u_props (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hresp(hresp), .hrdata(hrdata), .level(level), .output_on(output_on),
    .settling(settling));

// ---- rps_str_if.sv ----
// Purpose: Carries characters to and from the quoted string parser.
// Assumes: All signals belong to the hclk domain.
// Notes:   One character per cycle at most.
`timescale 1ns/10ps
interface rps_str_if;
    logic       in_vld;
    logic [7:0] in_chr;
    logic       out_vld;
    logic [7:0] out_chr;
    logic       open_p;
    logic       active;

    modport host  (output in_vld, output in_chr, input out_vld, input out_chr, input open_p, input active);
    modport parse (input in_vld, input in_chr, output out_vld, output out_chr, output open_p, output active);
endinterface

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the remote sync block.
// Assumes: Short settle count; the model drives the bus.
// Notes:   Random operands come from a fixed seed.
`timescale 1ns/10ps
module tb_top;
    import rps_pkg::*;
    localparam int unsigned S = 20;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp, output_on, settling, srq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [23:0] level;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          seed = 76;
    logic [15:0] qc [5] = '{16'h0000, 16'h007F, 16'h0080, 16'hFF80, 16'hFF7F};
    logic [7:0]  blk [5] = '{CH_HASH, CH_ONE, CH_TWO, 8'h00, 8'h08};

    rps_remote_sync #(.SETTLE_CYC(S)) dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .level(level), .output_on(output_on),
        .settling(settling), .srq(srq));
    rps_ctrl_model ctl (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] r;
        ctl.xfer(1'b0, {24'h0, a}, 32'h0, r);
        chk(r, e, w);
    endtask
    // An idle edge keeps the result read from racing the command.
    task automatic cmd(input logic [7:0] op, input logic [23:0] arg);
        logic [31:0] r;
        ctl.xfer(1'b1, {24'h0, ADDR_CMD}, {arg, op}, r);
        @(posedge hclk);
    endtask
    task automatic rstr(input string s);
        foreach (s[i]) rc(ADDR_RESP, {23'h0, 1'b1, s[i]}, "resp char");
        rc(ADDR_RESP, 32'h0, "resp end");
    endtask
    function automatic logic bon(input logic [15:0] v);
        logic [15:0] s;
        s = v + 16'h0080;
        return s[15:8] != 8'h00;
    endfunction
    function automatic string kw(input logic v, input logic c);
        if (c) return v ? "CURRENT" : "CURR";
        return v ? "VOLTAGE" : "VOLT";
    endfunction

    // ---
    // Clock, timeout and main sequence
    // ---
    always #4 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] q;
        int e;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(ADDR_SETTINGS, 32'h0, "settings reset");
        rc(ADDR_STATUS, 32'h0, "status reset");
        ctl.xfer(1'b1, {24'h0, ADDR_RESP}, 32'h1FF, r);
        rc(ADDR_RESP, 32'h0, "resp read-only");
        ctl.xfer(1'b0, 32'h100, 32'h0, r);
        chk(r, 32'h0, "unmapped");
        for (int i = 0; i < 12; i++) begin
            q = (i < 5) ? qc[i] : 16'($signed(10'($random(seed))));
            cmd(OP_OUTP, {8'h0, q});
            rc(ADDR_SETTINGS, {29'h0, bon(q), 2'h0}, "output");
            cmd(OP_BOOLQ, 24'h0);
            rstr(bon(q) ? "1" : "0");
        end
        for (int i = 0; i < 8; i++) begin
            cmd(OP_VERB, {8'h0, i[0] ? 16'h0100 : 16'h0000});
            cmd(OP_HEAD, {8'h0, i[1] ? 16'h0100 : 16'h0000});
            cmd(OP_FUNC, {23'h0, i[2]});
            cmd(OP_CHARQ, 24'h0);
            rstr(kw(i[0], i[2]));
        end
        ctl.send_str(CH_SQ, "A'B", 1'b1);
        cmd(OP_STRQ, 24'h0);
        rstr("\"A'B\"");
        ctl.send_str(CH_DQ, "XY", 1'b1);
        cmd(OP_STRQ, 24'h0);
        rstr("\"XY\"");
        ctl.send_str(CH_SQ, "QR;S", 1'b0);
        cmd(OP_STRQ, 24'h0);
        rstr("\"QR;S\"");
        cmd(OP_EESE, 24'h8);
        cmd(OP_SRE, 24'h8);
        for (int f = 0; f < 5; f++) begin
            if (f == 4) cmd(OP_EESE, 24'h0);
            cmd(OP_FILT, (f == 4) ? 24'h2 : 24'(f));
            cmd(OP_EESRQ, 24'h0);
            cmd(OP_LEVEL, 24'($random(seed)));
            cmd(OP_EESRQ, 24'h0);
            rc(ADDR_RESULT, {28'h0, f[0], 3'h0}, "event settling");
            cmd(OP_CONDQ, 24'h0);
            rc(ADDR_RESULT, 32'h8, "cond settling");
            cmd(OP_BLKQ, 24'h0);
            foreach (blk[j]) rc(ADDR_RESP, {23'h0, 1'b1, blk[j]}, "block");
            rc(ADDR_RESP, 32'h0, "block end");
            repeat (S + 4) @(posedge hclk);
            chk({31'h0, srq}, {31'h0, f[1] & ~f[2]}, "srq");
            cmd(OP_CONDQ, 24'h0);
            rc(ADDR_RESULT, 32'h0, "cond settled");
            cmd(OP_EESRQ, 24'h0);
            rc(ADDR_RESULT, {28'h0, f[1] | f[2], 3'h0}, "event settled");
            cmd(OP_EESRQ, 24'h0);
            rc(ADDR_RESULT, 32'h0, "event cleared");
            chk({31'h0, srq}, 32'h0, "srq cleared");
        end
        cmd(OP_LEVEL, 24'h00ABCD);
        e = cyc;
        cmd(OP_WAIT, 24'h000008);
        cmd(OP_LEVEL, 24'h001234);
        e = cyc - e;
        chk({31'h0, e >= S && e <= S + 8}, 32'h1, "wait hold time");
        conclude();
    end
endmodule
